// File: tgsr_defs.svh
`ifndef TGSR_DEFS_SVH
`define TGSR_DEFS_SVH

// Setup numbering and geometry
`define TGSR_MAX_SETUP       100
`define TGSR_UNIT_COLS       12
`define TGSR_LAST_ROW        3'h7
`define TGSR_FIFO_DEPTH      8
`define TGSR_STREAM_WIDTH    9

// Reset and default values, and command parameter limits
`define TGSR_TRIG_EN_DEFAULT 1'b0
`define TGSR_FMT_DEFAULT     3'h0
`define TGSR_STEP_DEFAULT    7'h00
`define TGSR_FMT_MAX         8'h07
`define TGSR_TRIG_EN_MAX     8'h01

// Output characters
`define TGSR_CH_OPEN         8'h2D
`define TGSR_CH_CLOSED       8'h58
`define TGSR_CH_COMMA        8'h2C
`define TGSR_CH_ROW_A        8'h41
`define TGSR_CH_ZERO         8'h30
`define TGSR_CH_HEX_BASE     8'h37
`define TGSR_DEC_BASE        7'h0A

`endif

// File: tgsr_pkg.sv
package tgsr_pkg;

   typedef enum logic [1:0] {
      OP_TRIG_EN  = 2'h0,
      OP_FORMAT   = 2'h1,
      OP_READOUT  = 2'h2,
      OP_DEFAULTS = 2'h3
   } tgsr_op_type;

   // Format groups taken from the upper two bits of the format code
   typedef enum logic [1:0] {
      GRP_FULL    = 2'h0,
      GRP_INSPECT = 2'h1,
      GRP_COND    = 2'h2,
      GRP_BINARY  = 2'h3
   } tgsr_grp_type;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_READ  = 3'h1,
      ST_WAIT  = 3'h3,
      ST_EMIT  = 3'h2,
      ST_FLUSH = 3'h6
   } tgsr_state_type;

endpackage

// File: tgsr_stream_if.sv
`timescale 1ns/100ps
`default_nettype none

interface tgsr_stream_if #(
   parameter int WIDTH = 9
);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// File: tgsr_fifo.sv
`timescale 1ns/100ps
`default_nettype none

module tgsr_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input  wire logic  ref_clk,
   input  wire logic  rst,
   tgsr_stream_if.snk wr,
   tgsr_stream_if.src rd
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW-1:0]    next_wr_ptr;
   logic [AW-1:0]    next_rd_ptr;
   logic [AW:0]      next_count;
   logic             do_wr;
   logic             do_rd;

   assign wr.ready = (count != (AW+1)'(DEPTH));
   assign rd.valid = (count != '0);
   assign rd.data  = mem[rd_ptr];

   always_comb begin
      do_wr       = wr.valid && wr.ready;
      do_rd       = rd.valid && rd.ready;
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count  = count;
      // Depth need not be a power of two, so wrap explicitly
      if (do_wr) begin
         next_wr_ptr = (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
      end
      if (do_rd) begin
         next_rd_ptr = (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
      end
      if (do_wr && !do_rd) begin
         next_count = count + (AW+1)'(1);
      end else if (do_rd && !do_wr) begin
         next_count = count - (AW+1)'(1);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   // Storage needs no reset; empty flag guards stale words
   always_ff @(posedge ref_clk) begin
      if (do_wr) begin
         mem[wr_ptr] <= wr.data;
      end
   end
endmodule

`default_nettype wire

// File: tgsr_trigger_readout.sv
`timescale 1ns/100ps
`default_nettype none
`include "tgsr_defs.svh"

module tgsr_trigger_readout
   import tgsr_pkg::*;
#(
   parameter int UNITS      = 1,
   parameter int UNIT_COLS  = `TGSR_UNIT_COLS,
   parameter int MAX_SETUP  = `TGSR_MAX_SETUP,
   parameter int FIFO_DEPTH = `TGSR_FIFO_DEPTH
) (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        cmd_valid,
   input  wire tgsr_op_type cmd_op,
   input  wire logic [7:0]  cmd_param,
   input  wire logic        dev_clear,
   input  wire logic        trig_source,
   input  wire logic        ext_trig,
   input  wire logic        bus_trig,
   output logic             cmd_busy,
   output logic             trig_enable,
   output logic [2:0]       data_format,
   output logic [6:0]       step_pointer,
   output logic             relay_load,
   output logic             mem_rd,
   output logic [6:0]       mem_setup,
   output logic [5:0]       mem_col,
   input  wire logic [7:0]  mem_data,
   output logic             out_valid,
   output logic [7:0]       out_data,
   output logic             out_eot,
   input  wire logic        out_ready
);
   localparam int NCOLS = UNITS * UNIT_COLS;

   function automatic logic [7:0] hex_char(input logic [3:0] v);
      hex_char = (v < 4'hA) ? `TGSR_CH_ZERO + {4'h0, v} : `TGSR_CH_HEX_BASE + {4'h0, v};
   endfunction

   tgsr_stream_if #(.WIDTH(`TGSR_STREAM_WIDTH)) wr_if ();
   tgsr_stream_if #(.WIDTH(`TGSR_STREAM_WIDTH)) rd_if ();

   tgsr_fifo #(
      .WIDTH (`TGSR_STREAM_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .ref_clk (ref_clk),
      .rst     (rst),
      .wr      (wr_if.snk),
      .rd      (rd_if.src)
   );

   assign out_valid   = rd_if.valid;
   assign out_data    = rd_if.data[7:0];
   assign out_eot     = rd_if.data[8];
   assign rd_if.ready = out_ready;

   // Command and trigger state
   logic       accept;
   logic       clear_all;
   logic       next_trig_enable;
   logic [2:0] next_data_format;
   logic [6:0] next_step_pointer;
   logic       next_relay_load;

   always_comb begin
      clear_all = dev_clear || (cmd_valid && cmd_op == OP_DEFAULTS);
      // Only the selected source counts, and only while enabled
      accept = trig_enable && (trig_source ? bus_trig : ext_trig);
      next_trig_enable  = trig_enable;
      next_data_format  = data_format;
      next_step_pointer = step_pointer;
      next_relay_load   = 1'b0;
      if (clear_all) begin
         next_trig_enable = `TGSR_TRIG_EN_DEFAULT;
         next_data_format = `TGSR_FMT_DEFAULT;
      end else if (cmd_valid && cmd_op == OP_TRIG_EN && cmd_param <= `TGSR_TRIG_EN_MAX) begin
         next_trig_enable = cmd_param[0];
      end else if (cmd_valid && cmd_op == OP_FORMAT && cmd_param <= `TGSR_FMT_MAX) begin
         next_data_format = cmd_param[2:0];
      end
      if (accept) begin
         // Step wraps past the last stored setup back to setup 1
         next_step_pointer = (step_pointer >= 7'(MAX_SETUP)) ? 7'h01 : step_pointer + 7'h01;
         next_relay_load   = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         trig_enable  <= `TGSR_TRIG_EN_DEFAULT;
         data_format  <= `TGSR_FMT_DEFAULT;
         step_pointer <= `TGSR_STEP_DEFAULT;
         relay_load   <= 1'b0;
      end else begin
         trig_enable  <= next_trig_enable;
         data_format  <= next_data_format;
         step_pointer <= next_step_pointer;
         relay_load   <= next_relay_load;
      end
   end

   // Readout sequencer
   tgsr_state_type state;
   tgsr_state_type next_state;
   logic [2:0]     run_fmt;
   logic [2:0]     next_run_fmt;
   logic [2:0]     row;
   logic [2:0]     next_row;
   logic [5:0]     col;
   logic [5:0]     next_col;
   logic [1:0]     sub;
   logic [1:0]     next_sub;
   logic           first;
   logic           next_first;
   logic [7:0]     col_byte;
   logic [7:0]     next_col_byte;
   logic [6:0]     next_mem_setup;
   logic           hold_valid;
   logic           next_hold_valid;
   logic [7:0]     hold_data;
   logic [7:0]     next_hold_data;
   logic           hold_eot;
   logic           next_hold_eot;
   tgsr_grp_type   grp;
   logic           gen;
   logic [7:0]     gen_ch;
   logic           gen_eot;
   logic           step_row;
   logic           col_end;
   logic           last_col;
   logic           unit_end;
   logic [6:0]     col_num;
   logic [3:0]     tens;
   logic [3:0]     ones;

   assign cmd_busy   = (state != ST_IDLE);
   assign mem_rd     = (state == ST_READ);
   assign mem_col    = col;
   // A held byte leaves either when its successor appears or at flush
   assign wr_if.valid = hold_valid && ((state == ST_EMIT && gen) || state == ST_FLUSH);
   assign wr_if.data  = {hold_eot || state == ST_FLUSH, hold_data};

   always_comb begin
      grp      = tgsr_grp_type'(run_fmt[2:1]);
      col_num  = {1'b0, col} + 7'h01;
      tens     = 4'(col_num / `TGSR_DEC_BASE);
      ones     = 4'(col_num % `TGSR_DEC_BASE);
      last_col = (int'(col) == NCOLS - 1);
      unit_end = ((int'(col_num) % UNIT_COLS) == 0);
      gen      = 1'b0;
      gen_ch   = 8'h00;
      gen_eot  = 1'b0;
      step_row = 1'b0;
      col_end  = 1'b0;
      case (grp)
         GRP_FULL: begin
            gen     = 1'b1;
            gen_ch  = col_byte[row] ? `TGSR_CH_CLOSED : `TGSR_CH_OPEN;
            gen_eot = run_fmt[0] && unit_end;
            col_end = 1'b1;
         end
         GRP_INSPECT: begin
            // Open points produce nothing
            if (!col_byte[row]) begin
               step_row = 1'b1;
            end else begin
               case (sub)
                  2'h0: begin
                     gen    = !first;
                     gen_ch = `TGSR_CH_COMMA;
                  end
                  2'h1: begin
                     gen    = 1'b1;
                     gen_ch = `TGSR_CH_ROW_A + {5'h00, row};
                  end
                  2'h2: begin
                     gen    = (tens != 4'h0);
                     gen_ch = `TGSR_CH_ZERO + {4'h0, tens};
                  end
                  default: begin
                     gen      = 1'b1;
                     gen_ch   = `TGSR_CH_ZERO + {4'h0, ones};
                     step_row = 1'b1;
                  end
               endcase
            end
            col_end = step_row && (row == `TGSR_LAST_ROW);
         end
         GRP_COND: begin
            gen     = 1'b1;
            gen_ch  = hex_char(sub[0] ? col_byte[3:0] : col_byte[7:4]);
            gen_eot = sub[0] && run_fmt[0] && unit_end;
            col_end = sub[0];
         end
         default: begin
            gen     = 1'b1;
            gen_ch  = col_byte;
            gen_eot = run_fmt[0] && unit_end;
            col_end = 1'b1;
         end
      endcase
   end

   always_comb begin
      next_state      = state;
      next_run_fmt    = run_fmt;
      next_row        = row;
      next_col        = col;
      next_sub        = sub;
      next_first      = first;
      next_col_byte   = col_byte;
      next_mem_setup  = mem_setup;
      next_hold_valid = hold_valid;
      next_hold_data  = hold_data;
      next_hold_eot   = hold_eot;
      case (state)
         ST_IDLE: begin
            // Only the readout command starts a stream
            if (cmd_valid && cmd_op == OP_READOUT && int'(cmd_param) <= MAX_SETUP) begin
               next_state      = ST_READ;
               next_run_fmt    = data_format;
               next_mem_setup  = cmd_param[6:0];
               next_row        = 3'h0;
               next_col        = 6'h00;
               next_sub        = 2'h0;
               next_first      = 1'b1;
               next_hold_valid = 1'b0;
            end
         end
         ST_READ: begin
            next_state = ST_WAIT;
         end
         ST_WAIT: begin
            next_col_byte = mem_data;
            next_state    = ST_EMIT;
         end
         ST_EMIT: begin
            // Stall only when a push meets a full buffer
            if (!(wr_if.valid && !wr_if.ready)) begin
               next_sub = sub + 2'h1;
               if (gen) begin
                  next_hold_valid = 1'b1;
                  next_hold_data  = gen_ch;
                  next_hold_eot   = gen_eot;
                  if (grp == GRP_INSPECT && sub == 2'h3) begin
                     next_first = 1'b0;
                  end
               end
               if (step_row) begin
                  next_sub = 2'h0;
                  next_row = row + 3'h1;
               end
               if (col_end) begin
                  next_sub   = 2'h0;
                  next_state = ST_READ;
                  if (!last_col) begin
                     next_col = col + 6'h01;
                  end else if (grp == GRP_FULL && row != `TGSR_LAST_ROW) begin
                     next_col = 6'h00;
                     next_row = row + 3'h1;
                  end else begin
                     next_state = ST_FLUSH;
                  end
               end
            end
         end
         default: begin
            // Last byte always closes the talk
            if (!hold_valid || wr_if.ready) begin
               next_hold_valid = 1'b0;
               next_state      = ST_IDLE;
            end
         end
      endcase
      if (clear_all) begin
         next_state      = ST_IDLE;
         next_hold_valid = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state      <= ST_IDLE;
         run_fmt    <= `TGSR_FMT_DEFAULT;
         row        <= 3'h0;
         col        <= 6'h00;
         sub        <= 2'h0;
         first      <= 1'b1;
         col_byte   <= 8'h00;
         mem_setup  <= 7'h00;
         hold_valid <= 1'b0;
         hold_data  <= 8'h00;
         hold_eot   <= 1'b0;
      end else begin
         state      <= next_state;
         run_fmt    <= next_run_fmt;
         row        <= next_row;
         col        <= next_col;
         sub        <= next_sub;
         first      <= next_first;
         col_byte   <= next_col_byte;
         mem_setup  <= next_mem_setup;
         hold_valid <= next_hold_valid;
         hold_data  <= next_hold_data;
         hold_eot   <= next_hold_eot;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   trig_ignored_a: assert property (
      !trig_enable && (ext_trig || bus_trig) |=> !relay_load && $stable(step_pointer))
      else $error("Trigger acted on while disabled");
   trig_step_a: assert property (
      accept && step_pointer < 7'(MAX_SETUP)
      |=> relay_load && step_pointer == $past(step_pointer) + 7'h01)
      else $error("Accepted trigger did not advance and load");
   clear_defaults_a: assert property (
      dev_clear |=> !trig_enable ##1 !relay_load)
      else $error("Clear left triggers enabled");
   format_default_a: assert property (
      dev_clear |=> data_format == 3'h0 && !cmd_busy)
      else $error("Clear did not restore format 0");
   trig_source_a: assert property (
      trig_enable && !trig_source && bus_trig && !ext_trig |=> !relay_load)
      else $error("Unselected source triggered");
   format_set_a: assert property (
      cmd_valid && cmd_op == OP_FORMAT && cmd_param <= 8'h07 && !dev_clear
      |=> data_format == 3'($past(cmd_param)))
      else $error("Format code not taken");
   readout_only_a: assert property (
      state == ST_IDLE && !(cmd_valid && cmd_op == OP_READOUT) |=> state == ST_IDLE)
      else $error("Stream began without readout command");
   full_chars_a: assert property (
      wr_if.valid && grp == GRP_FULL
      |-> wr_if.data[7:0] == 8'h2D || wr_if.data[7:0] == 8'h58)
      else $error("Bad full format character");
   single_talk_a: assert property (
      wr_if.valid && wr_if.data[8] && run_fmt == 3'h0 |-> state == ST_FLUSH)
      else $error("Mode 0 split into several talks");
   insp_chars_a: assert property (
      wr_if.valid && grp == GRP_INSPECT
      |-> wr_if.data[7:0] == 8'h2C || (wr_if.data[7:0] inside {[8'h41:8'h48]})
          || (wr_if.data[7:0] inside {[8'h30:8'h39]}))
      else $error("Bad inspect character");
   cond_hex_a: assert property (
      wr_if.valid && grp == GRP_COND
      |-> (wr_if.data[7:0] inside {[8'h30:8'h39]}) || (wr_if.data[7:0] inside {[8'h41:8'h46]}))
      else $error("Condensed character not hex");
   fetch_order_a: assert property (
      state == ST_READ && !clear_all
      |=> state == ST_WAIT ##1 (state == ST_EMIT || $past(clear_all)))
      else $error("Column fetch sequence broken");
endmodule

`default_nettype wire

// File: tgsr_partner.sv
`timescale 1ns/100ps
`default_nettype none

// Far side: setup memory and the controller's byte sink
module tgsr_partner (
   input  wire logic        ref_clk,
   input  wire logic [95:0] setup_bits,
   input  wire logic        hold,
   input  wire logic        slow,
   input  wire logic        mem_rd,
   input  wire logic [5:0]  mem_col,
   output logic [7:0]       mem_data,
   input  wire logic        out_valid,
   input  wire logic [7:0]  out_data,
   input  wire logic        out_eot,
   output logic             out_ready
);
   logic [1:0] phase;
   logic [8:0] got[$];

   initial begin
      phase = 2'h0;
      mem_data = 8'h00;
   end

   // Data only valid the cycle after a strobe; toggles otherwise to expose late sampling
   // Plain always: the initial block presets these as well
   always @(posedge ref_clk) begin
      phase <= phase + 2'h1;
      mem_data <= mem_rd ? setup_bits[mem_col*8 +: 8] : ~mem_data;
      if (out_valid && out_ready) begin
         got.push_back({out_eot, out_data});
      end
   end

   // Slow sink takes one byte in four cycles
   assign out_ready = !hold && (!slow || phase == 2'h0);
endmodule

`default_nettype wire

// File: test_trigger_gate_and_setup_readout.sv
`timescale 1ns/100ps
`default_nettype none

module test_trigger_gate_and_setup_readout
   import tgsr_pkg::*;
();
   typedef struct packed {
      logic [2:0] fmt;
      logic       slow;
      logic [6:0] setup;
      logic [7:0] count;
   } tgsr_row_type;

   // Closed: A1; B10, H10; A12, C12, F12, H12
   localparam logic [95:0] PAT = {8'hA5, 8'h00, 8'h82, 64'h0000_0000_0000_0000, 8'h01};

   logic         ref_clk, rst, cmd_valid, dev_clear, trig_source, ext_trig, bus_trig;
   logic         hold, slow, cmd_busy, trig_enable, relay_load, mem_rd, out_valid;
   logic         out_eot, out_ready;
   tgsr_op_type  cmd_op;
   logic [7:0]   cmd_param, mem_data, out_data;
   logic [2:0]   data_format;
   logic [6:0]   step_pointer, mem_setup;
   logic [5:0]   mem_col;
   logic [8:0]   exp_q[$];
   int           error_cnt, total_checks;
   tgsr_row_type rows [0:7];

   tgsr_trigger_readout dut_u (
      .ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
      .cmd_param(cmd_param), .dev_clear(dev_clear), .trig_source(trig_source),
      .ext_trig(ext_trig), .bus_trig(bus_trig), .cmd_busy(cmd_busy),
      .trig_enable(trig_enable), .data_format(data_format), .step_pointer(step_pointer),
      .relay_load(relay_load), .mem_rd(mem_rd), .mem_setup(mem_setup), .mem_col(mem_col),
      .mem_data(mem_data), .out_valid(out_valid), .out_data(out_data),
      .out_eot(out_eot), .out_ready(out_ready)
   );

   tgsr_partner partner_u (
      .ref_clk(ref_clk), .setup_bits(PAT), .hold(hold), .slow(slow), .mem_rd(mem_rd),
      .mem_col(mem_col), .mem_data(mem_data), .out_valid(out_valid),
      .out_data(out_data), .out_eot(out_eot), .out_ready(out_ready)
   );

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic conclude();
      $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tick();
      @(posedge ref_clk);
      #1;
   endtask

   // One spare cycle after each command keeps strobes from re-rising in one step
   task automatic cmd(input tgsr_op_type op, input logic [7:0] p);
      cmd_op = op;
      cmd_param = p;
      cmd_valid = 1'b1;
      tick();
      cmd_valid = 1'b0;
      tick();
   endtask

   task automatic trig(input logic use_bus, input logic [6:0] step, input logic load);
      bus_trig = use_bus;
      ext_trig = !use_bus;
      tick();
      bus_trig = 1'b0;
      ext_trig = 1'b0;
      chk(step_pointer, step);
      chk(relay_load, load);
      tick();
      chk(relay_load, 1'b0);
   endtask

   function automatic void push(input logic [7:0] b, input logic e);
      exp_q.push_back({e, b});
   endfunction

   function automatic logic [7:0] hexc(input logic [3:0] n);
      return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
   endfunction

   function automatic void build(input logic [2:0] fmt);
      logic [8:0] last;
      exp_q.delete();
      for (int r = 0; r < 8 && fmt[2:1] == 2'h0; r++) begin
         for (int c = 0; c < 12; c++) begin
            push(PAT[c*8+r] ? 8'h58 : 8'h2D, fmt[0] && c == 11);
         end
      end
      for (int c = 0; c < 12; c++) begin
         if (fmt[2:1] == 2'h1) begin
            for (int r = 0; r < 8; r++) begin
               if (PAT[c*8+r]) begin
                  if (exp_q.size() > 0) push(8'h2C, 1'b0);
                  push(8'h41 + r, 1'b0);
                  if (c >= 9) push(8'h30 + (c + 1) / 10, 1'b0);
                  push(8'h30 + (c + 1) % 10, 1'b0);
               end
            end
         end else if (fmt[2:1] == 2'h2) begin
            push(hexc(PAT[c*8+4 +: 4]), 1'b0);
            push(hexc(PAT[c*8 +: 4]), 1'b0);
         end else if (fmt[2:1] == 2'h3) begin
            push(PAT[c*8 +: 8], 1'b0);
         end
      end
      if (exp_q.size() > 0) begin
         last = exp_q.pop_back();
         exp_q.push_back(last | 9'h100);
      end
   endfunction

   task automatic start(input logic [2:0] fmt, input logic [6:0] setup);
      partner_u.got.delete();
      cmd(OP_FORMAT, {5'h00, fmt});
      chk(data_format, fmt);
      cmd(OP_READOUT, {1'b0, setup});
      chk(mem_setup, setup);
   endtask

   task automatic finish(input logic [2:0] fmt);
      int n;
      n = 0;
      while ((cmd_busy !== 1'b0 || out_valid !== 1'b0) && n < 3000) begin
         tick();
         n++;
      end
      chk(n < 3000, 1'b1);
      build(fmt);
      chk(partner_u.got.size(), exp_q.size());
      foreach (exp_q[i]) begin
         if (i < partner_u.got.size()) chk(partner_u.got[i], exp_q[i]);
      end
   endtask

   initial begin
      #200000;
      error_cnt++;
      conclude();
   end

   initial begin
      rows = '{'{3'h0, 1'b1, 7'h00, 8'h60}, '{3'h1, 1'b0, 7'h64, 8'h60},
               '{3'h2, 1'b0, 7'h01, 8'h1A}, '{3'h3, 1'b1, 7'h00, 8'h1A},
               '{3'h4, 1'b1, 7'h05, 8'h18}, '{3'h5, 1'b0, 7'h00, 8'h18},
               '{3'h6, 1'b0, 7'h63, 8'h0C}, '{3'h7, 1'b1, 7'h00, 8'h0C}};
      {cmd_valid, dev_clear, trig_source, ext_trig, bus_trig, hold, slow} = 7'h00;
      cmd_op = OP_TRIG_EN;
      cmd_param = 8'h00;
      error_cnt = 0;
      total_checks = 0;
      rst = 1'b1;
      repeat (16) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      foreach (rows[i]) begin
         slow = rows[i].slow;
         start(rows[i].fmt, rows[i].setup);
         finish(rows[i].fmt);
         chk(partner_u.got.size(), rows[i].count);
      end
      $display("Format table done");
      // Enable first so the reset check below can see it drop
      cmd(OP_TRIG_EN, 8'h01);
      rst = 1'b1;
      repeat (16) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      chk(trig_enable, 1'b0);
      chk(data_format, 3'h0);
      partner_u.got.delete();
      $display("Reset defaults done");
      trig(1'b0, 7'h00, 1'b0);
      cmd(OP_TRIG_EN, 8'h01);
      chk(trig_enable, 1'b1);
      trig(1'b0, 7'h01, 1'b1);
      trig(1'b1, 7'h01, 1'b0);
      cmd(OP_TRIG_EN, 8'h00);
      trig_source = 1'b1;
      trig(1'b1, 7'h01, 1'b0);
      cmd(OP_TRIG_EN, 8'h01);
      trig(1'b1, 7'h02, 1'b1);
      trig(1'b0, 7'h02, 1'b0);
      cmd(OP_TRIG_EN, 8'h02);
      chk(trig_enable, 1'b1);
      bus_trig = 1'b1;
      repeat (98) @(posedge ref_clk);
      #1;
      bus_trig = 1'b0;
      chk(step_pointer, 7'h64);
      tick();
      trig(1'b1, 7'h01, 1'b1);
      chk(partner_u.got.size(), 0);
      $display("Trigger gating done");
      for (int k = 0; k < 2; k++) begin
         cmd(OP_FORMAT, 8'h05);
         cmd(OP_TRIG_EN, 8'h01);
         if (k == 0) begin
            cmd(OP_DEFAULTS, 8'h00);
         end else begin
            dev_clear = 1'b1;
            tick();
            dev_clear = 1'b0;
            tick();
         end
         chk(trig_enable, 1'b0);
         chk(data_format, 3'h0);
         chk(step_pointer, 7'h01);
      end
      $display("Clear defaults done");
      cmd(OP_FORMAT, 8'h0D);
      chk(data_format, 3'h0);
      cmd(OP_READOUT, 8'h65);
      chk(cmd_busy, 1'b0);
      start(3'h6, 7'h01);
      dev_clear = 1'b1;
      tick();
      dev_clear = 1'b0;
      chk(cmd_busy, 1'b0);
      chk(data_format, 3'h0);
      repeat (20) tick();
      chk(partner_u.got.size() < 12, 1'b1);
      $display("Refusal and abort done");
      // Stalled sink: FIFO fills and generation must wait, not drop bytes
      hold = 1'b1;
      slow = 1'b0;
      start(3'h0, 7'h01);
      repeat (300) @(posedge ref_clk);
      #1;
      chk(out_valid, 1'b1);
      chk(cmd_busy, 1'b1);
      chk(partner_u.got.size(), 0);
      hold = 1'b0;
      finish(3'h0);
      $display("Back-pressure done");
      conclude();
   end
endmodule

`default_nettype wire
